// >>> shared/rblc_pkg.sv
// Constants, types and register map of the reset and block-lock controller
package rblc_pkg;

  // Register offsets (word addresses on the parallel bus)
  localparam logic [15:0] ADDR_COMMAND = 16'hf220;
  localparam logic [15:0] ADDR_SYS_CONFIG = 16'hf221;
  localparam logic [15:0] ADDR_BLOCK_SELECT = 16'hf24c;
  localparam logic [15:0] ADDR_PROTECT_STATUS = 16'hf24e;
  localparam logic [15:0] ADDR_BOOT_LAST = 16'h01ff;

  // Command codes
  localparam logic [15:0] CMD_UNLOCK = 16'h0023;
  localparam logic [15:0] CMD_LOCK = 16'h002a;
  localparam logic [15:0] CMD_LOCK_TIGHT = 16'h002c;
  localparam logic [15:0] CMD_CORE_RESET = 16'h00f0;
  localparam logic [15:0] CMD_HOT_RESET = 16'h00f3;

  // Reset values
  localparam logic [15:0] COMMAND_RESET = 16'h0000;
  localparam logic [15:0] SYS_CONFIG_RESET = 16'h40c0;
  localparam logic [15:0] STATUS_RESET = 16'h0002;
  localparam logic [15:0] BLOCK_SELECT_RESET = 16'h0000;

  // Configuration field positions
  localparam int CFG_READY_POL_BIT = 7;
  localparam int CFG_IRQ_POL_BIT = 6;
  localparam int CFG_IRQ_OE_BIT = 5;
  localparam logic [15:0] CFG_COLD_ONLY_MASK = 16'h00e0;

  // Protection status encodings, bits [2:0]
  localparam logic [2:0] STAT_UNLOCKED = 3'h4;
  localparam logic [2:0] STAT_LOCKED = 3'h2;
  localparam logic [2:0] STAT_TIGHT = 3'h1;

  // Array geometry
  localparam int BLOCK_COUNT = 512;
  localparam int BLOCK_AW = 9;
  localparam int BOOT_WORDS = 512;
  localparam int BOOT_AW = 9;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BOOT_WAIT_US = 400;
  localparam int BOOT_COPY_US = 70;
  localparam int BOOT_WAIT_CYCLES = (BOOT_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BOOT_COPY_CYCLES = (BOOT_COPY_US * 1000) / CLK_PERIOD_NS;

  // Per-block protection state
  typedef enum logic [1:0] {
    LK_UNLOCKED,
    LK_LOCKED,
    LK_TIGHT
  } rblc_lock_type;

  // Pending protection operation
  typedef enum logic [1:0] {
    OP_REFRESH,
    OP_UNLOCK,
    OP_LOCK,
    OP_TIGHT
  } rblc_op_type;

  // Protection sequencer states
  typedef enum logic [1:0] {
    PS_IDLE,
    PS_WAIT,
    PS_APPLY
  } rblc_pstate_type;

  // Boot loader states
  typedef enum logic [1:0] {
    BL_WAIT,
    BL_COPY,
    BL_DONE
  } rblc_boot_type;

  // Register access from the host bus
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] data;
  } rblc_reg_req_type;

  // Program or erase request on one block
  typedef struct packed {
    logic valid;
    logic [BLOCK_AW-1:0] block;
  } rblc_pe_req_type;

endpackage

// >>> rtl/rblc_lock_mem.sv
// Per-block protection state store with two registered read ports
`timescale 1ns/100ps
module rblc_lock_mem #(
  parameter int BLOCKS = rblc_pkg::BLOCK_COUNT,
  parameter int AW = rblc_pkg::BLOCK_AW
) (
  input wire logic sys_clk,
  input wire logic rstN,
  input wire logic clear,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire rblc_pkg::rblc_lock_type wrData,
  input wire logic [AW-1:0] rdAddrA,
  input wire logic [AW-1:0] rdAddrB,
  output rblc_pkg::rblc_lock_type rdDataA,
  output rblc_pkg::rblc_lock_type rdDataB
);
  import rblc_pkg::*;

  rblc_lock_type cell_q [BLOCKS];
  rblc_lock_type rdA_q, rdB_q;

  ////////////////////////////////////////////////////////////////////////
  // One state cell per block; clear returns every block to locked
  for (genvar i = 0; i < BLOCKS; i++) begin : g_cell
    rblc_lock_type cell_d;
    always_comb begin
      cell_d = cell_q[i];
      if (clear) begin
        cell_d = LK_LOCKED;
      end else if (wrEn && wrAddr == AW'(i)) begin
        cell_d = wrData;
      end
    end
    always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
        cell_q[i] <= LK_LOCKED;
      end else begin
        cell_q[i] <= cell_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered read ports
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      rdA_q <= LK_LOCKED;
      rdB_q <= LK_LOCKED;
    end else begin
      rdA_q <= cell_q[rdAddrA];
      rdB_q <= cell_q[rdAddrB];
    end
  end

  assign rdDataA = rdA_q;
  assign rdDataB = rdB_q;
endmodule

// >>> rtl/rblc_boot_loader.sv
// Boot code copy sequencer run after power-up reset
`timescale 1ns/100ps
module rblc_boot_loader #(
  parameter int WAIT_CYCLES = rblc_pkg::BOOT_WAIT_CYCLES,
  parameter int COPY_CYCLES = rblc_pkg::BOOT_COPY_CYCLES,
  parameter int WORDS = rblc_pkg::BOOT_WORDS
) (
  input wire logic sys_clk,
  input wire logic rstN,
  output logic copyWrEn,
  output logic [rblc_pkg::BOOT_AW-1:0] copyAddr,
  output logic copyActive,
  output logic loadDone
);
  import rblc_pkg::*;

  localparam int STEP = (COPY_CYCLES / WORDS > 0) ? COPY_CYCLES / WORDS : 1;

  rblc_boot_type state_q, state_d;
  logic [16:0] cnt_q, cnt_d;
  logic [BOOT_AW:0] word_q, word_d;
  logic wrEn_q, wrEn_d;

  ////////////////////////////////////////////////////////////////////////
  // Wait after reset, then copy one word every STEP cycles
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    word_d = word_q;
    wrEn_d = 1'b0;
    unique case (state_q)
      BL_WAIT: begin
        if (cnt_q == 17'(WAIT_CYCLES - 1)) begin
          state_d = BL_COPY;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + 17'h1;
        end
      end
      BL_COPY: begin
        if (cnt_q == 17'(STEP - 1)) begin
          cnt_d = '0;
          wrEn_d = 1'b1;
          word_d = word_q + (BOOT_AW + 1)'(1);
          if (word_q == (BOOT_AW + 1)'(WORDS - 1)) begin
            state_d = BL_DONE;
          end
        end else begin
          cnt_d = cnt_q + 17'h1;
        end
      end
      BL_DONE: begin
        state_d = BL_DONE;
      end
      default: state_d = BL_DONE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      state_q <= BL_WAIT;
      cnt_q <= '0;
      word_q <= '0;
      wrEn_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      word_q <= word_d;
      wrEn_q <= wrEn_d;
    end
  end

  assign copyWrEn = wrEn_q;
  assign copyAddr = BOOT_AW'(word_q - (BOOT_AW + 1)'(1));
  assign copyActive = (state_q == BL_COPY);
  assign loadDone = (state_q == BL_DONE);

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_COPY_START: assert property (@(posedge sys_clk) disable iff (!rstN)
    (state_q == BL_WAIT && cnt_q == 17'(WAIT_CYCLES - 1)) |=> copyActive)
    else $error("boot copy did not start after wait");
  AST_DONE_STAYS: assert property (@(posedge sys_clk) disable iff (!rstN)
    loadDone |=> loadDone && !copyWrEn)
    else $error("boot load done dropped");
endmodule

// >>> rtl/rblc_top.sv
// Reset sequencing and block write-protection controller
`timescale 1ns/100ps
module rblc_top #(
  parameter int BOOT_WAIT_CYCLES = rblc_pkg::BOOT_WAIT_CYCLES,
  parameter int BOOT_COPY_CYCLES = rblc_pkg::BOOT_COPY_CYCLES,
  parameter int BLOCKS = rblc_pkg::BLOCK_COUNT
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic hwResetInN,
  input wire rblc_pkg::rblc_reg_req_type regReq,
  output logic [15:0] regRdData,
  input wire logic intEvent,
  output logic intPinOut,
  output logic intPinOe,
  output logic readyPolarity,
  input wire rblc_pkg::rblc_pe_req_type peReq,
  output logic peGrant,
  output logic peRefuse,
  output logic coreAbort,
  output logic logicReset,
  output logic bootCopyWrEn,
  output logic [rblc_pkg::BOOT_AW-1:0] bootCopyAddr,
  output logic bootReadable,
  input wire logic hostBootWrReq,
  output logic hostBootWrGrant
);
  import rblc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Reset synchroniser: cold reset copy used by the whole design
  logic rstMeta_q, rstN;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_q <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN <= rstMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset event decode
  logic hwPrev_q, hwPrev_d;
  logic warmEdge, hotCmd, coreCmd, wrCmdReg, wrSel, protCmd;
  rblc_op_type cmdOp;

  always_comb begin
    hwPrev_d = hwResetInN;
  end
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      hwPrev_q <= 1'b1;
    end else begin
      hwPrev_q <= hwPrev_d;
    end
  end

  assign warmEdge = hwPrev_q && !hwResetInN;
  assign wrCmdReg = regReq.wr && regReq.addr == ADDR_COMMAND && hwResetInN;
  assign wrSel = regReq.wr && regReq.addr == ADDR_BLOCK_SELECT && hwResetInN;
  assign hotCmd = hwResetInN && regReq.wr &&
    ((regReq.addr == ADDR_COMMAND && regReq.data == CMD_HOT_RESET) ||
     (regReq.addr <= ADDR_BOOT_LAST && regReq.data == CMD_CORE_RESET));
  assign coreCmd = wrCmdReg && regReq.data == CMD_CORE_RESET;
  assign protCmd = wrCmdReg && (regReq.data == CMD_UNLOCK || regReq.data == CMD_LOCK ||
    regReq.data == CMD_LOCK_TIGHT);

  always_comb begin
    unique case (regReq.data)
      CMD_UNLOCK: cmdOp = OP_UNLOCK;
      CMD_LOCK: cmdOp = OP_LOCK;
      CMD_LOCK_TIGHT: cmdOp = OP_TIGHT;
      default: cmdOp = OP_REFRESH;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Host registers: command, configuration, block select
  logic [15:0] cmd_q, cmd_d, cfg_q, cfg_d;
  logic [BLOCK_AW-1:0] sel_q, sel_d;
  logic abort_q, abort_d, lrst_q, lrst_d;
  rblc_pstate_type pst_q, pst_d;

  always_comb begin
    cmd_d = cmd_q;
    cfg_d = cfg_q;
    sel_d = sel_q;
    abort_d = warmEdge || hotCmd || coreCmd;
    lrst_d = warmEdge || hotCmd;
    if (warmEdge || hotCmd) begin
      cmd_d = COMMAND_RESET;
      cfg_d = (cfg_q & CFG_COLD_ONLY_MASK) | (SYS_CONFIG_RESET & ~CFG_COLD_ONLY_MASK);
      if (warmEdge) begin
        sel_d = BLOCK_AW'(BLOCK_SELECT_RESET);
      end
    end else begin
      if (wrCmdReg && !coreCmd) begin
        cmd_d = regReq.data;
      end
      if (regReq.wr && regReq.addr == ADDR_SYS_CONFIG && hwResetInN) begin
        cfg_d = regReq.data;
      end
      if (wrSel && pst_q == PS_IDLE) begin
        sel_d = regReq.data[BLOCK_AW-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      cmd_q <= COMMAND_RESET;
      cfg_q <= SYS_CONFIG_RESET;
      sel_q <= BLOCK_AW'(BLOCK_SELECT_RESET);
      abort_q <= 1'b0;
      lrst_q <= 1'b0;
    end else begin
      cmd_q <= cmd_d;
      cfg_q <= cfg_d;
      sel_q <= sel_d;
      abort_q <= abort_d;
      lrst_q <= lrst_d;
    end
  end

  assign coreAbort = abort_q;
  assign logicReset = lrst_q;
  assign readyPolarity = cfg_q[CFG_READY_POL_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Block state store
  rblc_lock_type rdSel, rdPe, newState;
  logic memWr;

  rblc_lock_mem #(.BLOCKS(BLOCKS), .AW(BLOCK_AW)) u_mem (
    .sys_clk(sys_clk),
    .rstN(rstN),
    .clear(warmEdge),
    .wrEn(memWr),
    .wrAddr(sel_q),
    .wrData(newState),
    .rdAddrA(sel_q),
    .rdAddrB(peReq.block),
    .rdDataA(rdSel),
    .rdDataB(rdPe)
  );

  ////////////////////////////////////////////////////////////////////////
  // Protection sequencer: wait for the selected block's state, then apply
  logic [2:0] stat_q, stat_d;
  rblc_op_type op_q, op_d;
  logic allowed;

  always_comb begin
    newState = rdSel;
    allowed = 1'b1;
    unique case (op_q)
      OP_REFRESH: allowed = 1'b1;
      OP_UNLOCK: begin
        allowed = (rdSel == LK_LOCKED);
        newState = LK_UNLOCKED;
      end
      OP_LOCK: begin
        allowed = (rdSel == LK_UNLOCKED);
        newState = LK_LOCKED;
      end
      OP_TIGHT: begin
        allowed = (rdSel == LK_LOCKED);
        newState = LK_TIGHT;
      end
    endcase
  end

  always_comb begin
    pst_d = pst_q;
    op_d = op_q;
    stat_d = stat_q;
    memWr = 1'b0;
    if (warmEdge) begin
      pst_d = PS_IDLE;
      stat_d = STATUS_RESET[2:0];
    end else begin
      unique case (pst_q)
        PS_IDLE: begin
          if (wrSel || protCmd) begin
            pst_d = PS_WAIT;
            op_d = wrSel ? OP_REFRESH : cmdOp;
          end
        end
        PS_WAIT: pst_d = PS_APPLY;
        PS_APPLY: begin
          pst_d = PS_IDLE;
          if (op_q == OP_REFRESH) begin
            stat_d = (rdSel == LK_UNLOCKED) ? STAT_UNLOCKED :
              (rdSel == LK_TIGHT) ? STAT_TIGHT : STAT_LOCKED;
          end else if (allowed) begin
            memWr = 1'b1;
            stat_d = (newState == LK_UNLOCKED) ? STAT_UNLOCKED :
              (newState == LK_TIGHT) ? STAT_TIGHT : STAT_LOCKED;
          end
        end
        default: pst_d = PS_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      pst_q <= PS_IDLE;
      op_q <= OP_REFRESH;
      stat_q <= STATUS_RESET[2:0];
    end else begin
      pst_q <= pst_d;
      op_q <= op_d;
      stat_q <= stat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program and erase gate: answer one cycle after the request
  logic pePend_q, pePend_d;
  always_comb begin
    pePend_d = peReq.valid && !warmEdge && !hotCmd;
  end
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      pePend_q <= 1'b0;
    end else begin
      pePend_q <= pePend_d;
    end
  end
  assign peGrant = pePend_q && rdPe == LK_UNLOCKED;
  assign peRefuse = pePend_q && rdPe != LK_UNLOCKED;

  ////////////////////////////////////////////////////////////////////////
  // Boot loader and boot buffer protection
  logic copyActive, loadDone;
  rblc_boot_loader #(
    .WAIT_CYCLES(BOOT_WAIT_CYCLES),
    .COPY_CYCLES(BOOT_COPY_CYCLES),
    .WORDS(BOOT_WORDS)
  ) u_boot (
    .sys_clk(sys_clk),
    .rstN(rstN),
    .copyWrEn(bootCopyWrEn),
    .copyAddr(bootCopyAddr),
    .copyActive(copyActive),
    .loadDone(loadDone)
  );
  assign bootReadable = loadDone;
  assign hostBootWrGrant = hostBootWrReq && !copyActive && !loadDone;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt pin and register read-back
  logic intOut_q, intOut_d, intOe_q, intOe_d;
  logic [15:0] rd_q, rd_d;

  always_comb begin
    intOe_d = cfg_q[CFG_IRQ_OE_BIT];
    intOut_d = cfg_q[CFG_IRQ_OE_BIT] && (intEvent == cfg_q[CFG_IRQ_POL_BIT]);
    rd_d = rd_q;
    if (regReq.rd) begin
      unique case (regReq.addr)
        ADDR_COMMAND: rd_d = cmd_q;
        ADDR_SYS_CONFIG: rd_d = cfg_q;
        ADDR_BLOCK_SELECT: rd_d = 16'(sel_q);
        ADDR_PROTECT_STATUS: rd_d = 16'(stat_q);
        default: rd_d = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      intOut_q <= 1'b0;
      intOe_q <= 1'b0;
      rd_q <= '0;
    end else begin
      intOut_q <= intOut_d;
      intOe_q <= intOe_d;
      rd_q <= rd_d;
    end
  end

  assign intPinOut = intOut_q;
  assign intPinOe = intOe_q;
  assign regRdData = rd_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstN);

  sequence s_selWrite;
    wrSel && pst_q == PS_IDLE && !warmEdge;
  endsequence
  sequence s_refreshDone;
    ##2 pst_q == PS_APPLY ##1 pst_q == PS_IDLE;
  endsequence

  AST_REFRESH_SEQ: assert property (s_selWrite |-> s_refreshDone)
    else $error("status refresh did not complete in three cycles");
  AST_LOCK_APPLIED: assert property (
    pst_q == PS_APPLY && op_q == OP_LOCK && rdSel == LK_UNLOCKED && !warmEdge |=> stat_q == STAT_LOCKED)
    else $error("lock did not lock an unlocked block");
  AST_UNLOCK_APPLIED: assert property (
    pst_q == PS_APPLY && op_q == OP_UNLOCK && rdSel == LK_LOCKED && !warmEdge |=> stat_q == STAT_UNLOCKED)
    else $error("unlock did not release a locked block");
  AST_TIGHT_NEEDS_LOCKED: assert property (
    pst_q == PS_APPLY && op_q == OP_TIGHT && rdSel != LK_LOCKED && !warmEdge |=> $stable(stat_q) && !$past(memWr))
    else $error("lock-tight applied to a block that was not locked");
  AST_TIGHT_IGNORES: assert property (
    pst_q == PS_APPLY && op_q != OP_REFRESH && rdSel == LK_TIGHT |-> !memWr)
    else $error("locked-tight block changed by command");
  AST_WARM_LOCKS: assert property (warmEdge |=> stat_q == STAT_LOCKED && sel_q == '0)
    else $error("warm reset did not relock");
  AST_HOT_KEEPS_STATUS: assert property (
    hotCmd && !warmEdge && pst_q != PS_APPLY |=> $stable(stat_q) && logicReset)
    else $error("hot reset disturbed protection status");
  AST_IRQ_GATED: assert property (!cfg_q[CFG_IRQ_OE_BIT] |=> !intPinOut && !intPinOe)
    else $error("interrupt pin active while disabled");
  AST_CORE_ONLY: assert property (
    coreCmd && !warmEdge && pst_q != PS_APPLY |=> coreAbort && !logicReset && $stable(cfg_q) && $stable(stat_q))
    else $error("core reset touched registers");
  AST_PE_GATE: assert property (peGrant |-> $past(peReq.valid) && !peRefuse)
    else $error("program or erase granted without request");
  AST_COLD_ONLY_BITS: assert property (
    warmEdge |=> (cfg_q & CFG_COLD_ONLY_MASK) == ($past(cfg_q) & CFG_COLD_ONLY_MASK))
    else $error("warm reset altered cold-only configuration bits");
  AST_BOOT_LOCK: assert property (loadDone |-> !hostBootWrGrant)
    else $error("boot buffer write after load");
endmodule

// >>> sim/rblc_host_model.sv
// Host-side model that drives the register bus, the reset pin and program requests
`timescale 1ns/100ps
module rblc_host_model
  import rblc_pkg::*;
(
  sys_clk,
  regRdData,
  peGrant,
  peRefuse,
  regReq,
  hwResetInN,
  peReq
);
  input wire logic sys_clk;
  input wire logic [15:0] regRdData;
  input wire logic peGrant;
  input wire logic peRefuse;
  output rblc_pkg::rblc_reg_req_type regReq;
  output logic hwResetInN;
  output rblc_pkg::rblc_pe_req_type peReq;

  // Idle bus and released reset pin from time zero
  initial begin
    regReq = '0;
    hwResetInN = 1'b1;
    peReq = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write held over one taken edge, then spacing for the protection sequencer
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    regReq = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(posedge sys_clk);
    #1 regReq = '0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  // Read taken on one edge, data sampled one cycle later
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    regReq = '{wr: 1'b0, rd: 1'b1, addr: a, data: 16'h0};
    @(posedge sys_clk);
    #1 regReq = '0;
    @(posedge sys_clk);
    #1 d = regRdData;
  endtask

  // Program request; answer stands in the cycle after the taken edge
  task automatic pe(input logic [8:0] b, output logic [1:0] g);
    peReq = '{valid: 1'b1, block: b};
    @(posedge sys_clk);
    #1 peReq = '0;
    g = {peGrant, peRefuse};
    @(posedge sys_clk);
    #1;
  endtask

  // Block address first, then the command code
  task automatic protect(input logic [8:0] b, input logic [15:0] c);
    wr(ADDR_BLOCK_SELECT, {7'h0, b});
    wr(ADDR_COMMAND, c);
  endtask

  // Reset pin held low for 200ns
  task automatic warm();
    hwResetInN = 1'b0;
    repeat (20) @(posedge sys_clk);
    #1 hwResetInN = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
endmodule

// >>> sim/reset_and_block_lock_control_test.sv
// Self-checking bench of the reset and block-lock controller
`timescale 1ns/100ps
module reset_and_block_lock_control_test;
  import rblc_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic intEvent = 1'b1;
  logic hostBootWrReq = 1'b1;
  rblc_reg_req_type regReq;
  rblc_pe_req_type peReq;
  logic [15:0] regRdData;
  logic [8:0] bootCopyAddr;
  logic hwResetInN, intPinOut, intPinOe, readyPolarity, peGrant, peRefuse;
  logic coreAbort, logicReset, bootCopyWrEn, bootReadable, hostBootWrGrant;
  int errors = 0;
  int check_count = 0;
  int nAbort = 0;
  int nLogic = 0;
  int nCopy = 0;
  int cycles = 0;
  rblc_lock_type lk [BLOCK_COUNT];
  localparam logic [15:0] CMDS [3] = '{CMD_UNLOCK, CMD_LOCK, CMD_LOCK_TIGHT};
  localparam logic [15:0] CORNER [6] = '{CMD_UNLOCK, CMD_LOCK_TIGHT, CMD_LOCK, CMD_LOCK_TIGHT, CMD_UNLOCK, CMD_LOCK};

  always #5 sys_clk = ~sys_clk;

  rblc_top #(.BOOT_WAIT_CYCLES(20), .BOOT_COPY_CYCLES(1024), .BLOCKS(512)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .hwResetInN(hwResetInN), .regReq(regReq),
    .regRdData(regRdData), .intEvent(intEvent), .intPinOut(intPinOut), .intPinOe(intPinOe),
    .readyPolarity(readyPolarity), .peReq(peReq), .peGrant(peGrant), .peRefuse(peRefuse),
    .coreAbort(coreAbort), .logicReset(logicReset), .bootCopyWrEn(bootCopyWrEn),
    .bootCopyAddr(bootCopyAddr), .bootReadable(bootReadable), .hostBootWrReq(hostBootWrReq),
    .hostBootWrGrant(hostBootWrGrant));

  rblc_host_model host (.sys_clk(sys_clk), .regRdData(regRdData), .peGrant(peGrant),
    .peRefuse(peRefuse), .regReq(regReq), .hwResetInN(hwResetInN), .peReq(peReq));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Next protection state of one block for a command
  function automatic rblc_lock_type next_lock(rblc_lock_type s, logic [15:0] c);
    if (s == LK_TIGHT) return s;
    if (c == CMD_UNLOCK) return LK_UNLOCKED;
    if (c == CMD_LOCK) return LK_LOCKED;
    return (s == LK_LOCKED) ? LK_TIGHT : s;
  endfunction

  function automatic logic [15:0] stat_of(rblc_lock_type s);
    return {13'h0, (s == LK_UNLOCKED) ? 3'b100 : (s == LK_LOCKED) ? 3'b010 : 3'b001};
  endfunction

  // Pulse counters, copy order and run ceiling, sampled away from the active edge
  always @(negedge sys_clk) begin
    cycles++;
    if (coreAbort === 1'b1) nAbort++;
    if (logicReset === 1'b1) nLogic++;
    if (bootCopyWrEn === 1'b1) begin
      chk_word({7'h0, bootCopyAddr}, 16'(nCopy), "copy address");
      nCopy++;
    end
    if (cycles == 10000) begin
      errors++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] d;
    logic [15:0] c;
    logic [8:0] b;
    logic [1:0] g;
    d = $urandom(32'hfaf9);
    for (int i = 0; i < BLOCK_COUNT; i++) lk[i] = LK_LOCKED;
    repeat (8) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    repeat (15) @(posedge sys_clk);
    #1;
    chk_word(16'(nCopy), 16'h0, "copy before wait");
    chk_bit(bootReadable, 1'b0, "readable early");
    chk_bit(intPinOe, 1'b0, "irq enable");
    chk_bit(intPinOut, 1'b0, "irq pin");
    chk_bit(readyPolarity, SYS_CONFIG_RESET[CFG_READY_POL_BIT], "ready polarity at power-up");
    chk_bit(hostBootWrGrant, 1'b1, "boot write before copy");
    host.rd(ADDR_PROTECT_STATUS, d);
    chk_word(d, 16'h0002, "status at power-up");
    for (int i = 0; i < 3000 && bootReadable !== 1'b1; i++) @(posedge sys_clk);
    // Let the last copy pulse be counted before the totals are compared
    repeat (2) @(posedge sys_clk);
    #1;
    chk_word(16'(nCopy), 16'd512, "copied words");
    chk_bit(bootReadable, 1'b1, "readable");
    chk_bit(hostBootWrGrant, 1'b0, "boot write");
    $display("test cold reset done");
    for (int i = 0; i < 60; i++) begin
      b = 9'($urandom_range(0, 4));
      c = CMDS[$urandom_range(0, 2)];
      if (b == 9'd4) b = 9'h1ff;
      if (i < 6) c = CORNER[i];
      if (i < 6) b = 9'h1ff;
      host.wr(ADDR_BLOCK_SELECT, {7'h0, b});
      host.rd(ADDR_PROTECT_STATUS, d);
      chk_word(d, stat_of(lk[b]), "status on select");
      host.wr(ADDR_COMMAND, c);
      lk[b] = next_lock(lk[b], c);
      host.rd(ADDR_PROTECT_STATUS, d);
      chk_word(d, stat_of(lk[b]), "status after command");
      host.pe(b, g);
      chk_word({14'h0, g}, {14'h0, lk[b] == LK_UNLOCKED, lk[b] != LK_UNLOCKED}, "grant");
    end
    $display("test protection done");
    intEvent = 1'b0;
    host.wr(ADDR_SYS_CONFIG, 16'h0020);
    chk_bit(intPinOe, 1'b1, "irq enable set");
    chk_bit(intPinOut, 1'b1, "irq pin active");
    host.wr(ADDR_COMMAND, CMD_CORE_RESET);
    chk_word(16'(nAbort), 16'd1, "core abort");
    chk_word(16'(nLogic), 16'd0, "core no logic reset");
    host.rd(ADDR_SYS_CONFIG, d);
    chk_word(d, 16'h0020, "config after core reset");
    host.protect(b, CMD_HOT_RESET);
    chk_word(16'(nAbort), 16'd2, "hot abort");
    chk_word(16'(nLogic), 16'd1, "hot logic reset");
    host.rd(ADDR_PROTECT_STATUS, d);
    chk_word(d, stat_of(lk[b]), "status after hot");
    host.rd(ADDR_SYS_CONFIG, d);
    chk_word(d, 16'h4020, "config after hot");
    host.wr(16'h0010, CMD_CORE_RESET);
    chk_word(16'(nLogic), 16'd2, "boot area hot reset");
    $display("test command resets done");
    host.warm();
    chk_word(16'(nAbort), 16'd4, "warm abort");
    chk_bit(bootReadable, 1'b1, "boot kept");
    chk_bit(intPinOe, 1'b1, "irq enable kept");
    chk_bit(readyPolarity, 1'b0, "ready polarity kept");
    chk_word(16'(nLogic), 16'd3, "warm logic reset");
    host.rd(ADDR_SYS_CONFIG, d);
    chk_word(d, 16'h4020, "config after warm");
    for (int j = 0; j < 5; j++) begin
      host.wr(ADDR_BLOCK_SELECT, (j == 4) ? 16'h01ff : 16'(j));
      host.rd(ADDR_PROTECT_STATUS, d);
      chk_word(d, 16'h0002, "locked after warm");
    end
    $display("test warm reset done");
    report_and_stop();
  end
endmodule
